// file: rtl/ccco_pkg.sv
// constants, opcode patterns and types for the call / clear / decrement execution block
// assumes a 14-bit instruction word and an 8-bit data path
package ccco_pkg;

  // widths
  localparam int PC_W    = 13;
  localparam int INSTR_W = 14;
  localparam int DATA_W  = 8;
  localparam int FADDR_W = 7;

  // apb byte offsets, one aligned word each
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] WORK_OFS   = 8'h08;
  localparam logic [7:0] LATCH_OFS  = 8'h0c;
  localparam logic [7:0] PC_OFS     = 8'h10;
  localparam logic [7:0] STACK_OFS  = 8'h14;
  localparam logic [7:0] WDOG_OFS   = 8'h18;
  localparam logic [7:0] FADDR_OFS  = 8'h1c;
  localparam logic [7:0] FDATA_OFS  = 8'h20;

  // status field positions
  localparam int Z_BIT     = 2;
  localparam int PWRDN_BIT = 3;
  localparam int TMOUT_BIT = 4;
  // pc high latch bits feeding pc[12:11]
  localparam int LATCH_HI = 4;
  localparam int LATCH_LO = 3;
  localparam int LATCH_W  = 5;

  // values after reset
  localparam logic [PC_W-1:0]    PC_RST     = 13'h0000;
  localparam logic [DATA_W-1:0]  STATUS_RST = 8'h18;
  localparam logic [DATA_W-1:0]  BYTE_ZERO  = 8'h00;
  localparam logic [LATCH_W-1:0] LATCH_RST  = 5'h00;
  localparam logic [FADDR_W-1:0] FADDR_RST  = 7'h00;

  // steps
  localparam logic [PC_W-1:0]   RET_STEP = 13'h0001;
  localparam logic [DATA_W-1:0] DEC_STEP = 8'h01;
  localparam logic [DATA_W-1:0] ONE_STEP = 8'h01;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;

  // opcode masks and match values
  localparam logic [INSTR_W-1:0] CALL_MASK  = 14'h3800;
  localparam logic [INSTR_W-1:0] CALL_VAL   = 14'h2000;
  localparam logic [INSTR_W-1:0] WDOG_VAL   = 14'h0064;
  localparam logic [INSTR_W-1:0] BYTE_MASK  = 14'h3f00;
  localparam logic [INSTR_W-1:0] COMPL_VAL  = 14'h0900;
  localparam logic [INSTR_W-1:0] DECR_VAL   = 14'h0300;
  localparam logic [INSTR_W-1:0] CLR_MASK   = 14'h3f80;
  localparam logic [INSTR_W-1:0] FCLR_VAL   = 14'h0180;
  localparam logic [INSTR_W-1:0] WCLR_VAL   = 14'h0100;
  localparam int                 DEST_BIT   = 7;

  // decoded operations
  typedef enum logic [2:0] {
    OP_NONE, OP_CALL, OP_WDOG, OP_COMPL, OP_FCLR, OP_WCLR, OP_DECR
  } ccco_op_e;

  // sequencing states
  typedef enum logic {ST_EXEC, ST_FLUSH} ccco_state_e;

endpackage : ccco_pkg

// file: rtl/ccco_decode.sv
// instruction decode and byte result for the execution block
// assumes a combinational caller that registers everything it uses
`timescale 1ns/1ps
module ccco_decode #(
  parameter int DW = 8
) (
  // instruction and operands
  input  wire logic [13:0]      instr,
  input  wire logic [DW-1:0]    file_val,
  // decoded outputs
  output ccco_pkg::ccco_op_e    op,
  output logic      [DW-1:0]    result,
  output logic                  zero,
  output logic                  to_file
);

  // opcode match and byte result
  always_comb begin
    op      = ccco_pkg::OP_NONE;
    result  = '0;
    to_file = instr[ccco_pkg::DEST_BIT];
    if ((instr & ccco_pkg::CALL_MASK) == ccco_pkg::CALL_VAL) begin
      op = ccco_pkg::OP_CALL;
    end else if (instr == ccco_pkg::WDOG_VAL) begin
      op = ccco_pkg::OP_WDOG;
    end else if ((instr & ccco_pkg::BYTE_MASK) == ccco_pkg::COMPL_VAL) begin
      op     = ccco_pkg::OP_COMPL;
      result = ~file_val;
    end else if ((instr & ccco_pkg::BYTE_MASK) == ccco_pkg::DECR_VAL) begin
      op     = ccco_pkg::OP_DECR;
      result = file_val - ccco_pkg::DEC_STEP;
    end else if ((instr & ccco_pkg::CLR_MASK) == ccco_pkg::FCLR_VAL) begin
      op      = ccco_pkg::OP_FCLR;
      to_file = 1'b1;
    end else if ((instr & ccco_pkg::CLR_MASK) == ccco_pkg::WCLR_VAL) begin
      op      = ccco_pkg::OP_WCLR;
      to_file = 1'b0;
    end
    zero = (result == '0);
  end

endmodule : ccco_decode

// file: rtl/ccco_core.sv
// execution core for call, watchdog clear, complement, clear and decrement
// assumes program memory answers combinationally on prog_addr, same clock, apb slave access
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps

module ccco_core #(
  parameter int FILE_WORDS = 128
) (
  // clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           rst,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic      [31:0]                    prdata,
  output logic                                pready,
  output logic                                pslverr,
  // program memory
  output logic      [ccco_pkg::PC_W-1:0]      prog_addr,
  output logic                                prog_rd,
  input  wire logic [ccco_pkg::INSTR_W-1:0]   prog_data,
  input  wire logic                           prog_valid
);

  // architectural state
  logic [ccco_pkg::PC_W-1:0]    pc_reg, pc_next;         // program counter
  logic [ccco_pkg::PC_W-1:0]    stack_top_reg, stack_top_next;
  logic [7:0]                   work_reg, work_next;     // working register
  logic [7:0]                   status_reg, status_next; // z, powerdown, timeout
  logic [ccco_pkg::LATCH_W-1:0] pc_high_latch_reg, pc_high_latch_next;
  logic [7:0]                   wdog_cnt_reg, wdog_cnt_next; // watchdog count
  logic [7:0]                   presc_reg, presc_next;
  logic [6:0]                   faddr_reg, faddr_next;   // software file pointer
  logic                         run_reg, run_next;       // fetch enable
  logic [7:0]                   file_reg  [FILE_WORDS];
  logic [7:0]                   file_next [FILE_WORDS];
  ccco_pkg::ccco_state_e        state_reg, state_next;
  // apb answer state
  logic [31:0]                  prdata_reg, prdata_next;
  logic                         pready_reg, pready_next;
  logic                         pslverr_reg, pslverr_next;

  // decode
  ccco_pkg::ccco_op_e op;
  logic [7:0]         dec_res;   // byte result
  logic               dec_zero;  // result is zero
  logic               dec_file;  // result goes to file
  logic [7:0]         file_val;  // addressed file byte
  logic               exec;      // instruction executes this cycle
  logic               apb_done;  // apb completion edge
  logic               apb_wr;    // write takes effect
  logic               hit;       // mapped offset
  logic [31:0]        rd_val;    // read mux

  assign file_val = file_reg[prog_data[6:0]];
  assign exec     = run_reg && prog_valid && (state_reg == ccco_pkg::ST_EXEC);
  assign apb_done = psel && penable && pready_reg;
  assign apb_wr   = apb_done && pwrite;

  ccco_decode #(.DW(8)) u_decode (
    .instr    (prog_data),
    .file_val (file_val),
    .op       (op),
    .result   (dec_res),
    .zero     (dec_zero),
    .to_file  (dec_file)
  );

  // apb read mux and one wait state
  always_comb begin
    hit    = 1'b1;
    rd_val = '0;
    unique case (paddr)
      ccco_pkg::CTRL_OFS:   rd_val[0]   = run_reg;
      ccco_pkg::STATUS_OFS: rd_val[7:0] = status_reg;
      ccco_pkg::WORK_OFS:   rd_val[7:0] = work_reg;
      ccco_pkg::LATCH_OFS:  rd_val[ccco_pkg::LATCH_W-1:0] = pc_high_latch_reg;
      ccco_pkg::PC_OFS:     rd_val[ccco_pkg::PC_W-1:0] = pc_reg;
      ccco_pkg::STACK_OFS:  rd_val[ccco_pkg::PC_W-1:0] = stack_top_reg;
      ccco_pkg::WDOG_OFS:   rd_val[15:0] = {presc_reg, wdog_cnt_reg};
      ccco_pkg::FADDR_OFS:  rd_val[6:0] = faddr_reg;
      ccco_pkg::FDATA_OFS:  rd_val[7:0] = file_reg[faddr_reg];
      default:              hit = 1'b0; // unmapped: error, reads zero
    endcase
    pready_next  = psel && penable && !pready_reg;
    prdata_next  = pready_next ? rd_val : prdata_reg;
    pslverr_next = pready_next ? !hit : 1'b0;
  end

  // apb answer registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // core next state: software writes first, execution overrides
  always_comb begin
    pc_next            = pc_reg;
    stack_top_next     = stack_top_reg;
    work_next          = work_reg;
    status_next        = status_reg;
    pc_high_latch_next = pc_high_latch_reg;
    faddr_next         = faddr_reg;
    run_next           = run_reg;
    state_next         = state_reg;
    file_next          = file_reg;
    // free-running watchdog, count steps when prescaler wraps
    presc_next   = presc_reg + ccco_pkg::ONE_STEP;
    wdog_cnt_next = (presc_reg == ccco_pkg::ALL_ONES) ? wdog_cnt_reg + ccco_pkg::ONE_STEP
                                                       : wdog_cnt_reg;
    // software writes
    if (apb_wr) begin
      unique case (paddr)
        ccco_pkg::CTRL_OFS:   run_next = pwdata[0];
        ccco_pkg::STATUS_OFS: status_next = pwdata[7:0];
        ccco_pkg::WORK_OFS:   work_next = pwdata[7:0];
        ccco_pkg::LATCH_OFS:  pc_high_latch_next = pwdata[ccco_pkg::LATCH_W-1:0];
        ccco_pkg::FADDR_OFS:  faddr_next = pwdata[6:0];
        ccco_pkg::FDATA_OFS:  file_next[faddr_reg] = pwdata[7:0];
        default: ;            // read-only or unmapped: ignored
      endcase
    end
    // flush slot after a call: fetched target waits one cycle
    if (state_reg == ccco_pkg::ST_FLUSH) begin
      state_next = ccco_pkg::ST_EXEC;
    end
    if (exec) begin
      pc_next = pc_reg + ccco_pkg::RET_STEP;
      unique case (op)
        ccco_pkg::OP_CALL: begin
          stack_top_next = pc_reg + ccco_pkg::RET_STEP;
          pc_next = {pc_high_latch_reg[ccco_pkg::LATCH_HI:ccco_pkg::LATCH_LO],
                     prog_data[10:0]};
          state_next = ccco_pkg::ST_FLUSH;
        end
        ccco_pkg::OP_WDOG: begin
          wdog_cnt_next = ccco_pkg::BYTE_ZERO;
          presc_next    = ccco_pkg::BYTE_ZERO;
          status_next[ccco_pkg::TMOUT_BIT] = 1'b1;
          status_next[ccco_pkg::PWRDN_BIT] = 1'b1;
        end
        ccco_pkg::OP_COMPL, ccco_pkg::OP_DECR, ccco_pkg::OP_FCLR: begin
          // destination bit chooses file or working register
          if (dec_file) begin
            file_next[prog_data[6:0]] = dec_res;
          end else begin
            work_next = dec_res;
          end
          status_next[ccco_pkg::Z_BIT] = dec_zero;
        end
        ccco_pkg::OP_WCLR: begin
          work_next = ccco_pkg::BYTE_ZERO;
          status_next[ccco_pkg::Z_BIT] = 1'b1;
        end
        default: ; // other opcodes just advance
      endcase
    end
  end

  // core registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pc_reg            <= ccco_pkg::PC_RST;
      stack_top_reg     <= ccco_pkg::PC_RST;
      work_reg          <= ccco_pkg::BYTE_ZERO;
      status_reg        <= ccco_pkg::STATUS_RST;
      pc_high_latch_reg <= ccco_pkg::LATCH_RST;
      wdog_cnt_reg      <= ccco_pkg::BYTE_ZERO;
      presc_reg         <= ccco_pkg::BYTE_ZERO;
      faddr_reg         <= ccco_pkg::FADDR_RST;
      run_reg           <= 1'b0;
      state_reg         <= ccco_pkg::ST_EXEC;
      for (int i = 0; i < FILE_WORDS; i++) begin
        file_reg[i] <= ccco_pkg::BYTE_ZERO;
      end
    end else begin
      pc_reg            <= pc_next;
      stack_top_reg     <= stack_top_next;
      work_reg          <= work_next;
      status_reg        <= status_next;
      pc_high_latch_reg <= pc_high_latch_next;
      wdog_cnt_reg      <= wdog_cnt_next;
      presc_reg         <= presc_next;
      faddr_reg         <= faddr_next;
      run_reg           <= run_next;
      state_reg         <= state_next;
      file_reg          <= file_next;
    end
  end

  // outputs straight from flops
  assign prdata    = prdata_reg;
  assign pready    = pready_reg;
  assign pslverr   = pslverr_reg;
  assign prog_addr = pc_reg;
  assign prog_rd   = run_reg;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence call_issue_s;
    exec && op == ccco_pkg::OP_CALL;
  endsequence
  sequence call_slots_s;
    state_reg == ccco_pkg::ST_FLUSH ##1 state_reg == ccco_pkg::ST_EXEC;
  endsequence

  call_push_a: assert property (
    call_issue_s |=> stack_top_reg == $past(pc_reg) + ccco_pkg::RET_STEP)
    else $error("call did not push return address");
  call_low_a: assert property (
    call_issue_s |=> pc_reg[10:0] == $past(prog_data[10:0]))
    else $error("call target low bits wrong");
  call_high_a: assert property (
    call_issue_s |=> pc_reg[12:11] == $past(pc_high_latch_reg[4:3]) ##0 call_slots_s)
    else $error("call high bits or two-cycle timing wrong");
  watchdog_clear_a: assert property (
    exec && op == ccco_pkg::OP_WDOG |=> wdog_cnt_reg == 8'h00 && presc_reg == 8'h00)
    else $error("watchdog not cleared");
  watchdog_flags_a: assert property (
    exec && op == ccco_pkg::OP_WDOG && !apb_wr
    |=> status_reg == ($past(status_reg) | 8'h18))
    else $error("watchdog clear status bits wrong");
  compl_work_a: assert property (
    exec && op == ccco_pkg::OP_COMPL && !dec_file |=> work_reg == ~$past(file_val))
    else $error("complement result wrong");
  fclear_file_a: assert property (
    exec && op == ccco_pkg::OP_FCLR
    |=> file_reg[$past(prog_data[6:0])] == 8'h00 && status_reg[ccco_pkg::Z_BIT])
    else $error("clear file failed");
  decr_work_a: assert property (
    exec && op == ccco_pkg::OP_DECR && !dec_file |=> work_reg == $past(file_val) - 8'h01)
    else $error("decrement result wrong");
  wclear_work_a: assert property (
    exec && op == ccco_pkg::OP_WCLR |=> work_reg == 8'h00 && status_reg[ccco_pkg::Z_BIT])
    else $error("clear working register failed");
  // expected zero worked out from the operand, not from the decoder's result
  zero_flag_a: assert property (
    exec && (op == ccco_pkg::OP_COMPL || op == ccco_pkg::OP_DECR)
    |=> status_reg[ccco_pkg::Z_BIT] == ((($past(op) == ccco_pkg::OP_COMPL) ? ~$past(file_val)
                                         : $past(file_val) - 8'h01) == 8'h00))
    else $error("zero flag mismatch");
  single_cycle_a: assert property (
    exec && op != ccco_pkg::OP_CALL
    |=> state_reg == ccco_pkg::ST_EXEC && pc_reg == $past(pc_reg) + 13'h0001)
    else $error("single-cycle op did not advance");

endmodule : ccco_core

// file: verification/ccco_prog_mem.sv
// program memory model answering in the same cycle as the address
// assumes the core presents prog_addr from a register; the bench loads mem
`timescale 1ns/1ps
module ccco_prog_mem (
  // fetch side
  input  wire logic [12:0] prog_addr,
  input  wire logic        stall,
  output logic      [13:0] prog_data,
  output logic             prog_valid
);
  logic [13:0] mem [0:8191]; // instruction words

  // a stalled slot shows the inverse word, never a stale match
  always_comb begin
    prog_valid = !stall;
    prog_data  = stall ? ~mem[prog_addr] : mem[prog_addr];
  end
endmodule : ccco_prog_mem

// file: verification/core_call_clear_ops_tb.sv
// bench: random program against a reference model, results read back over apb
// assumes ccco_core answers apb with wait states and executes from a same-cycle memory
`timescale 1ns/1ps
module core_call_clear_ops_tb;
  // design and bench signals
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic        prog_rd, prog_valid, stall;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, r, seed;
  logic [12:0] prog_addr;
  logic [13:0] prog_data;
  int          fails, total_checks, cyc, clr_cyc, n, since;
  // reference state
  logic [7:0]  m_w, m_file [0:127];
  logic [4:0]  m_latch;
  logic [12:0] m_pc, m_stack;
  logic        m_z, m_pwrdn, m_tmout, m_flush;

  ccco_core dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr), .prog_rd(prog_rd),
    .prog_data(prog_data), .prog_valid(prog_valid));
  ccco_prog_mem u_mem (.prog_addr(prog_addr), .stall(stall),
    .prog_data(prog_data), .prog_valid(prog_valid));

  // 40 mhz clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  // one apb transfer; read data lands in rd
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic err_exp);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      report_and_stop();
    end else begin
      rd = prdata;
      check({31'h0, pslverr}, {31'h0, err_exp});
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  // reference model: one instruction per enabled edge, a call leaves a dead slot
  always @(posedge core_clk) begin : ref_model
    logic [13:0] ins;
    logic [7:0]  v, res;
    if (!rst) cyc++;
    // the dead slot after a call passes even while fetch is switched off
    if (!rst && m_flush) begin
      m_flush = 1'b0;
    end else if (!rst && prog_rd === 1'b1 && prog_valid === 1'b1) begin
      ins = u_mem.mem[m_pc];
      v   = m_file[ins[6:0]];
      res = (ins[13:8] == 6'h09) ? ~v : v - 8'h01;
      if (ins[13:11] == 3'b100) begin
        m_stack = m_pc + 13'h0001;
        m_pc    = {m_latch[4:3], ins[10:0]};
        m_flush = 1'b1;
      end else begin
        m_pc = m_pc + 13'h0001;
        if (ins == 14'h0064) begin
          m_tmout = 1'b1;
          m_pwrdn = 1'b1;
          clr_cyc = cyc;
        end else if (ins[13:7] == 7'h03) begin
          m_file[ins[6:0]] = 8'h00;
          m_z = 1'b1;
        end else if (ins[13:7] == 7'h02) begin
          m_w = 8'h00;
          m_z = 1'b1;
        end else if (ins[13:8] == 6'h09 || ins[13:8] == 6'h03) begin
          m_z = (res == 8'h00);
          if (ins[7]) m_file[ins[6:0]] = res;
          else m_w = res;
        end
      end
    end
    if (!rst && prog_rd === 1'b1) begin
      // stall only plain slots
      stall <= !m_flush && u_mem.mem[m_pc][13:11] != 3'b100 && rnd() % 4 == 0;
    end
  end

  // program counter follows the reference every cycle
  always @(negedge core_clk) begin
    if (!rst) check({19'h0, prog_addr}, {19'h0, m_pc});
  end

  // read back working register, status, stack, watchdog and file bytes 0..7
  task automatic compare_all();
    apb(1'b0, ccco_pkg::WORK_OFS, 32'h0, 1'b0);
    check(rd, {24'h0, m_w});
    apb(1'b0, ccco_pkg::STATUS_OFS, 32'h0, 1'b0);
    check(rd, {27'h0, m_tmout, m_pwrdn, m_z, 2'b00});
    apb(1'b0, ccco_pkg::STACK_OFS, 32'h0, 1'b0);
    check(rd, {19'h0, m_stack});
    apb(1'b0, ccco_pkg::WDOG_OFS, 32'h0, 1'b0);
    since = cyc - clr_cyc;
    // prescaler restarts at the clear, count only checked away from a wrap
    check({31'h0, 8'(rd[15:8] - since[7:0] + 8'd3) < 8'd7}, 32'h1);
    if (since[7:0] > 8 && since[7:0] < 248) check(rd[7:0], since >> 8);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ccco_pkg::FADDR_OFS, i, 1'b0);
      apb(1'b0, ccco_pkg::FDATA_OFS, 32'h0, 1'b0);
      check(rd, {24'h0, m_file[i]});
    end
  endtask : compare_all

  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    stall = 1'b0;
    seed = 32'h5b21;
    {fails, total_checks, cyc, clr_cyc} = '0;
    {m_w, m_latch, m_pc, m_stack, m_z, m_flush} = '0;
    {m_pwrdn, m_tmout} = 2'b11;
    foreach (m_file[i]) m_file[i] = 8'h00;
    // random program of every kind, operands on file bytes 0..7
    for (int i = 0; i < 8192; i++) begin
      r = rnd();
      case (r % 6)
        0: u_mem.mem[i] = {3'b100, r[18:8]};
        1: u_mem.mem[i] = 14'h0064;
        2: u_mem.mem[i] = {6'h09, r[7], 4'h0, r[10:8]};
        3: u_mem.mem[i] = {7'h03, 4'h0, r[10:8]};
        4: u_mem.mem[i] = {7'h02, r[14:8]};
        default: u_mem.mem[i] = {6'h03, r[7], 4'h0, r[10:8]};
      endcase
    end
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, read-only and unmapped places
    apb(1'b0, ccco_pkg::STATUS_OFS, 32'h0, 1'b0);
    check(rd, 32'h18);
    apb(1'b1, ccco_pkg::PC_OFS, 32'h55, 1'b0);
    apb(1'b0, ccco_pkg::PC_OFS, 32'h0, 1'b0);
    check(rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0, 1'b1);
    check(rd, 32'h0);
    // random start state
    for (int i = 0; i < 8; i++) begin
      m_file[i] = 8'(rnd());
      apb(1'b1, ccco_pkg::FADDR_OFS, i, 1'b0);
      apb(1'b1, ccco_pkg::FDATA_OFS, {24'h0, m_file[i]}, 1'b0);
    end
    m_latch = 5'(rnd());
    apb(1'b1, ccco_pkg::LATCH_OFS, {27'h0, m_latch}, 1'b0);
    m_w = 8'(rnd());
    apb(1'b1, ccco_pkg::WORK_OFS, {24'h0, m_w}, 1'b0);
    apb(1'b1, ccco_pkg::STATUS_OFS, 32'h0, 1'b0);
    {m_tmout, m_pwrdn, m_z} = 3'b000;
    // bursts of execution, each followed by a full readback
    repeat (6) begin
      apb(1'b1, ccco_pkg::CTRL_OFS, 32'h1, 1'b0);
      repeat (40 + rnd() % 200) @(posedge core_clk);
      apb(1'b1, ccco_pkg::CTRL_OFS, 32'h0, 1'b0);
      compare_all();
    end
    apb(1'b0, ccco_pkg::LATCH_OFS, 32'h0, 1'b0);
    check(rd, {27'h0, m_latch});
    report_and_stop();
  end
endmodule : core_call_clear_ops_tb
